/* File: hw/atsr_pkg.sv */
/*
  atsr_pkg: constants and types shared by the translation request responder
  and its completion entry builder.
  assumes: one 50 MHz clock domain; no timing counts are needed.
*/
`default_nettype none

package atsr_pkg;

  // fault reason codes
  localparam logic [3:0] FR_CTX_PROG  = 4'h3;
  localparam logic [3:0] FR_PTE_FETCH = 4'h7;
  localparam logic [3:0] FR_ROOT_TBL  = 4'h8;
  localparam logic [3:0] FR_CTX_TBL   = 4'h9;
  localparam logic [3:0] FR_ROOT_RSVD = 4'ha;
  localparam logic [3:0] FR_CTX_RSVD  = 4'hb;
  localparam logic [3:0] FR_PTE_RSVD  = 4'hc;

  // completion status codes
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_CA = 3'h4;

  // completion data entry bit positions
  localparam int ENT_R   = 0;
  localparam int ENT_W   = 1;
  localparam int ENT_N   = 2;
  localparam int ENT_U   = 9;
  localparam int ENT_S   = 11;
  localparam int ENT_ADR = 12;

  // interrupt window: address bits 31:20, upper word zero
  localparam logic [11:0] INTR_WIN = 12'hfee;
  // guest width for context_addr_width code n is AGAW_BASE + LVL_BITS*n
  localparam int AGAW_BASE = 30;
  localparam int LVL_BITS  = 9;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CLEAR  = 8'h08;
  localparam logic [7:0] REG_ENABLE = 8'h0c;
  localparam logic [7:0] REG_FCOUNT = 8'h10;
  localparam logic [7:0] REG_LAST   = 8'h14;

  // control fields and reset values
  localparam int CTRL_MAX_GUEST_ADDR_WIDTH_LSB  = 0;
  localparam int CTRL_SAGAW_LSB = 8;
  localparam logic [5:0] CTRL_MAX_GUEST_ADDR_WIDTH_RST  = 6'h30;
  localparam logic [4:0] CTRL_SAGAW_RST = 5'h06;

  // status bits
  localparam int ST_FAULT   = 0;
  localparam int ST_ABORT   = 1;
  localparam int ST_SUCCESS = 2;
  localparam int ST_QUIET   = 3;
  localparam int ST_W       = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WALK = 2'b01,
    ST_CPL  = 2'b10
  } atsr_state_t;

  typedef enum logic [1:0] {
    KIND_ABORT = 2'b00,
    KIND_INTR  = 2'b01,
    KIND_EMPTY = 2'b10,
    KIND_XLATE = 2'b11
  } atsr_kind_t;

endpackage

`default_nettype wire

/* File: hw/atsr_entry_build.sv */
/*
  atsr_entry_build: forms the 64-bit translation completion data entry
  from the outcome kind and the page walk results.
  assumes: inputs are stable in the cycle the entry is captured.
*/
`timescale 1ns/1ps
`default_nettype none

module atsr_entry_build (
  input  wire logic               kind_abort,
  input  wire logic               kind_intr,
  input  wire logic               kind_empty,
  input  wire logic               perm_r,
  input  wire logic               perm_w,
  input  wire logic               snoop_control_bit,
  input  wire logic               transient_mapping_bit,
  input  wire logic [1:0]         page_level,
  input  wire logic [51:0]        phys_page,
  output logic      [63:0]        entry
);

  wire  [5:0]  sp_bits   = 6'(atsr_pkg::LVL_BITS * int'(page_level));
  wire  [51:0] span_mask = (52'h1 << sp_bits) - 52'h1;
  // low-order ones below the first zero encode the super-page size
  wire  [51:0] adr_field = (phys_page & ~span_mask) | (span_mask >> 1);
  wire         superpage = (page_level != 2'h0);

  always_comb begin
    entry = 64'h0;
    if (kind_intr) begin
      entry[atsr_pkg::ENT_W] = 1'b1;
      entry[atsr_pkg::ENT_U] = 1'b1;
    end else if (!kind_abort && !kind_empty) begin
      entry[atsr_pkg::ENT_R] = perm_r;
      entry[atsr_pkg::ENT_W] = perm_w;
      entry[atsr_pkg::ENT_N] = snoop_control_bit;
      entry[atsr_pkg::ENT_U] = transient_mapping_bit;
      entry[atsr_pkg::ENT_S] = superpage;
      entry[63:atsr_pkg::ENT_ADR] = adr_field;
    end
  end

endmodule

`default_nettype wire

/* File: hw/atsr_responder.sv */
/*
  atsr_responder: answers single-address translation requests from an
  endpoint with a device translation cache, using walk results from the
  page walker, reporting faults to the fault recorder, and exposing control,
  sticky status and an interrupt over a plain register port.
  assumes: walker and requester run on clk_sys; walker answers each
  walk_req with exactly one walk_done pulse.
*/
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - bad context programming: qualified 3h, abort
// - next-level entry fetch error: qualified 7h
// - root table read error: unqualified 8h
// - context table read error: unqualified 9h
// - root entry reserved bits: unqualified Ah
// - context entry reserved bits: unqualified Bh
// - leaf reserved bits with permission: qualified Ch
// - every such failure returns Completer Abort
// - qualified faults reported only if enabled
// - error checks take precedence over success
// - interrupt window: R0 W1 U1 S0 success
// - address beyond width: empty success entry
// - non-present non-leaf entry: empty success entry
// - no cumulative permission: empty success entry
// - R and W are cumulative walk permissions
// - N from snoop, U from transient bit
// - S clear for 4KB, super-page size encoded
// - U never alters R and W
module atsr_responder (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic [63:0]        req_addr,
  input  wire logic [15:0]        req_rid,
  input  wire logic [7:0]         req_tag,
  output logic                    walk_req,
  output logic      [63:0]        walk_addr,
  output logic      [15:0]        walk_rid,
  input  wire logic               walk_done,
  input  wire logic               walk_fault,
  input  wire logic [3:0]         walk_reason,
  input  wire logic               fault_report_disable,
  input  wire logic [2:0]         context_addr_width,
  input  wire logic               walk_nonleaf_np,
  input  wire logic               walk_r,
  input  wire logic               walk_w,
  input  wire logic               snoop_control_bit,
  input  wire logic               transient_mapping_bit,
  input  wire logic [1:0]         walk_level,
  input  wire logic [51:0]        walk_paddr,
  output logic                    cpl_valid,
  input  wire logic               cpl_ready,
  output logic      [2:0]         cpl_status,
  output logic      [15:0]        cpl_rid,
  output logic      [7:0]         cpl_tag,
  output logic      [63:0]        cpl_entry,
  output logic                    flt_valid,
  output logic      [3:0]         flt_reason,
  output logic                    flt_qualified,
  output logic      [15:0]        flt_rid,
  output logic      [63:0]        flt_addr,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  output logic                    irq
);

  // qualified codes depend on the context entry's report-disable bit
  function automatic logic is_qualified(input logic [3:0] reason);
    is_qualified = (reason == atsr_pkg::FR_CTX_PROG)  ||
                   (reason == atsr_pkg::FR_PTE_FETCH) ||
                   (reason == atsr_pkg::FR_PTE_RSVD);
  endfunction

  // true when addr exceeds 2^x - 1, x = min(max_guest_addr_width, guest width of aw)
  function automatic logic addr_beyond(input logic [63:0] addr,
                                       input logic [5:0]  max_guest_addr_width,
                                       input logic [2:0]  aw);
    logic [6:0] agaw;
    logic [6:0] x;
    agaw = 7'(atsr_pkg::AGAW_BASE + atsr_pkg::LVL_BITS * int'(aw));
    x    = ({1'b0, max_guest_addr_width} < agaw) ? {1'b0, max_guest_addr_width} : agaw;
    addr_beyond = (x < 7'd64) ? ((addr >> x) != 64'h0) : 1'b0;
  endfunction

  atsr_pkg::atsr_state_t state_q;
  atsr_pkg::atsr_state_t state_d;

  logic [63:0] addr_q;
  logic [15:0] rid_q;
  logic [7:0]  tag_q;
  logic        walk_req_q;
  logic [2:0]  cpl_status_q;
  logic [63:0] cpl_entry_q;
  logic        flt_valid_q;
  logic [3:0]  flt_reason_q;
  logic        flt_qual_q;
  logic [5:0]  max_guest_addr_width_q;
  logic [4:0]  sagaw_q;
  logic [atsr_pkg::ST_W-1:0] status_q;
  logic [atsr_pkg::ST_W-1:0] enable_q;
  logic [15:0] fcount_q;
  logic [31:0] rdata_q;

  // request handshake
  wire accept = req_valid && req_ready;
  wire cpl_go = cpl_valid && cpl_ready;
  assign req_ready = (state_q == atsr_pkg::ST_IDLE);

  // the walker's results are sampled only in the walk_done cycle;
  // outside it they may hold stale values and are never looked at
  // walk result decoding
  // an unsupported width code is a context programming fault even
  // when the walker itself saw nothing wrong
  wire aw_ok     = (context_addr_width < 3'h5) && sagaw_q[context_addr_width];
  wire err       = walk_fault || !aw_ok;
  wire [3:0] rsn = walk_fault ? walk_reason : atsr_pkg::FR_CTX_PROG;
  wire qual      = is_qualified(rsn);
  wire report    = err && (!qual || !fault_report_disable);
  wire in_intr   = (addr_q[63:32] == 32'h0) && (addr_q[31:20] == atsr_pkg::INTR_WIN);
  wire beyond    = addr_beyond(addr_q, max_guest_addr_width_q, context_addr_width);
  wire no_perm   = !(walk_r || walk_w);

  atsr_pkg::atsr_kind_t kind;
  // a fault beats every success case; the window test precedes the rest
  assign kind = err             ? atsr_pkg::KIND_ABORT :
                in_intr         ? atsr_pkg::KIND_INTR  :
                beyond          ? atsr_pkg::KIND_EMPTY :
                walk_nonleaf_np ? atsr_pkg::KIND_EMPTY :
                no_perm         ? atsr_pkg::KIND_EMPTY :
                                  atsr_pkg::KIND_XLATE;

  wire is_abort = (kind == atsr_pkg::KIND_ABORT);
  wire [2:0] status_sel = is_abort ? atsr_pkg::CPL_CA : atsr_pkg::CPL_SC;

  wire [63:0] entry_w;

  atsr_entry_build u_entry (
    .kind_abort            (is_abort),
    .kind_intr             (kind == atsr_pkg::KIND_INTR),
    .kind_empty            (kind == atsr_pkg::KIND_EMPTY),
    .perm_r                (walk_r),
    .perm_w                (walk_w),
    .snoop_control_bit     (snoop_control_bit),
    .transient_mapping_bit (transient_mapping_bit),
    .page_level            (walk_level),
    .phys_page             (walk_paddr),
    .entry                 (entry_w)
  );

  // walk results are only meaningful while a walk is outstanding
  wire done_ok = (state_q == atsr_pkg::ST_WALK) && walk_done;

  // one request in flight: req_ready stays low from acceptance until
  // the completion is taken, so a second request simply waits
  // a walker that never answers leaves the block in the walk state;
  // there is no timeout here, the walker owns that guarantee
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      atsr_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = atsr_pkg::ST_WALK;
        end
      end
      atsr_pkg::ST_WALK: begin
        if (walk_done) begin
          state_d = atsr_pkg::ST_CPL;
        end
      end
      atsr_pkg::ST_CPL: begin
        if (cpl_ready) begin
          state_d = atsr_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = atsr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= atsr_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request capture; requester and tag are echoed in the completion
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_q     <= 64'h0;
      rid_q      <= 16'h0;
      tag_q      <= 8'h0;
      walk_req_q <= 1'b0;
    end else begin
      walk_req_q <= accept;
      if (accept) begin
        addr_q <= req_addr;
        rid_q  <= req_rid;
        tag_q  <= req_tag;
      end
    end
  end

  // completion capture at the end of the walk
  // an abort carries no permissions, so its entry is forced to zero
  // rather than trusting whatever the builder made of the results
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpl_status_q <= atsr_pkg::CPL_SC;
      cpl_entry_q  <= 64'h0;
    end else if (done_ok) begin
      cpl_status_q <= status_sel;
      cpl_entry_q  <= is_abort ? 64'h0 : entry_w;
    end
  end

  // fault record, one pulse per reported fault
  // reason and qualification are kept for every abort, reported or
  // not, so software can still read why a quiet fault happened
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flt_valid_q  <= 1'b0;
      flt_reason_q <= 4'h0;
      flt_qual_q   <= 1'b0;
    end else begin
      flt_valid_q <= done_ok && report;
      if (done_ok && err) begin
        flt_reason_q <= rsn;
        flt_qual_q   <= qual;
      end
    end
  end

  assign walk_req      = walk_req_q;
  assign walk_addr     = addr_q;
  assign walk_rid      = rid_q;
  assign cpl_valid     = (state_q == atsr_pkg::ST_CPL);
  assign cpl_status    = cpl_status_q;
  assign cpl_rid       = rid_q;
  assign cpl_tag       = tag_q;
  assign cpl_entry     = cpl_entry_q;
  assign flt_valid     = flt_valid_q;
  assign flt_reason    = flt_reason_q;
  assign flt_qualified = flt_qual_q;
  assign flt_rid       = rid_q;
  assign flt_addr      = addr_q;

  // register port decode
  wire wr_ctrl   = reg_wr && (reg_addr == atsr_pkg::REG_CTRL);
  wire wr_clear  = reg_wr && (reg_addr == atsr_pkg::REG_CLEAR);
  wire wr_enable = reg_wr && (reg_addr == atsr_pkg::REG_ENABLE);

  // status events; suppressed qualified faults still count as aborts
  wire [atsr_pkg::ST_W-1:0] ev;
  assign ev[atsr_pkg::ST_FAULT]   = done_ok && report;
  assign ev[atsr_pkg::ST_ABORT]   = done_ok && is_abort;
  assign ev[atsr_pkg::ST_SUCCESS] = done_ok && !is_abort;
  assign ev[atsr_pkg::ST_QUIET]   = done_ok && err && !report;

  wire [atsr_pkg::ST_W-1:0] clr_mask = wr_clear ? reg_wdata[atsr_pkg::ST_W-1:0] : '0;
  // a new event in the clearing cycle survives the clear
  wire [atsr_pkg::ST_W-1:0] status_d = (status_q & ~clr_mask) | ev;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      max_guest_addr_width_q   <= atsr_pkg::CTRL_MAX_GUEST_ADDR_WIDTH_RST;
      sagaw_q  <= atsr_pkg::CTRL_SAGAW_RST;
      enable_q <= '0;
      status_q <= '0;
      fcount_q <= 16'h0;
    end else begin
      status_q <= status_d;
      if (wr_ctrl) begin
        max_guest_addr_width_q  <= reg_wdata[atsr_pkg::CTRL_MAX_GUEST_ADDR_WIDTH_LSB +: 6];
        sagaw_q <= reg_wdata[atsr_pkg::CTRL_SAGAW_LSB +: 5];
      end
      if (wr_enable) begin
        enable_q <= reg_wdata[atsr_pkg::ST_W-1:0];
      end
      // the count wraps silently; software must sample it often enough
      if (ev[atsr_pkg::ST_FAULT]) begin
        fcount_q <= fcount_q + 16'h1;
      end
    end
  end

  // read mux; clear register reads as zero, unmapped offsets too
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (reg_addr)
      atsr_pkg::REG_CTRL: begin
        rd_mux[atsr_pkg::CTRL_MAX_GUEST_ADDR_WIDTH_LSB +: 6]  = max_guest_addr_width_q;
        rd_mux[atsr_pkg::CTRL_SAGAW_LSB +: 5] = sagaw_q;
      end
      atsr_pkg::REG_STATUS: begin
        rd_mux[atsr_pkg::ST_W-1:0] = status_q;
      end
      atsr_pkg::REG_ENABLE: begin
        rd_mux[atsr_pkg::ST_W-1:0] = enable_q;
      end
      atsr_pkg::REG_FCOUNT: begin
        rd_mux[15:0] = fcount_q;
      end
      atsr_pkg::REG_LAST: begin
        rd_mux[3:0] = flt_reason_q;
        rd_mux[4]   = flt_qual_q;
        rd_mux[7:5] = cpl_status_q;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // read data is zero outside the cycle after a read strobe, which
  // keeps a shared read-data bus free of stale values
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign reg_rdata = rdata_q;
  // level interrupt: stays high until software clears the status bit or its enable bit
  assign irq       = |(status_q & enable_q);

endmodule

`default_nettype wire

/* File: tb/atsr_responder_asserts.sv */
/*
  atsr_asserts: port-level checks of the translation request responder.
  assumes: bound into atsr_responder, one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module atsr_asserts (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        walk_req,
  input wire logic [63:0] walk_addr,
  input wire logic        walk_fault,
  input wire logic        walk_r,
  input wire logic        walk_w,
  input wire logic        snoop_control_bit,
  input wire logic        transient_mapping_bit,
  input wire logic [1:0]  walk_level,
  input wire logic        cpl_valid,
  input wire logic        cpl_ready,
  input wire logic [2:0]  cpl_status,
  input wire logic [15:0] cpl_rid,
  input wire logic [63:0] cpl_entry,
  input wire logic        flt_valid,
  input wire logic [3:0]  flt_reason,
  input wire logic        flt_qualified,
  input wire logic [15:0] flt_rid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire win = walk_addr[63:20] == 44'h00000000fee;
  wire ok  = cpl_status == atsr_pkg::CPL_SC;

  accept_walk_a: assert property (walk_req |-> $past(req_valid && req_ready) && !req_ready)
    else $error("walk request without accepted request");
  cpl_hold_a: assert property (cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_entry) && $stable(cpl_rid))
    else $error("completion dropped or changed before taken");
  abort_zero_a: assert property (cpl_valid && !ok |-> cpl_status == atsr_pkg::CPL_CA && cpl_entry == 64'h0)
    else $error("abort with bad status or entry");
  fault_abort_a: assert property (flt_valid |-> cpl_valid && !ok && flt_rid == cpl_rid)
    else $error("reported fault without abort");
  fault_qual_a: assert property (flt_valid |-> flt_qualified == (flt_reason inside {4'h3, 4'h7, 4'hc}))
    else $error("fault qualification wrong");
  err_first_a: assert property ($rose(cpl_valid) && $past(walk_fault) |-> !ok)
    else $error("walk error answered with success");
  intr_win_a: assert property (cpl_valid && ok && win |-> cpl_entry == 64'h0000000000000202)
    else $error("interrupt window entry wrong");
  no_perm_a: assert property ($rose(cpl_valid) && ok && !win && !$past(walk_r || walk_w) |-> cpl_entry == 64'h0)
    else $error("entry not empty without permission");
  perm_copy_a: assert property ($rose(cpl_valid) && ok && !win && cpl_entry[1:0] != 2'h0
    |-> cpl_entry[1:0] == {$past(walk_w), $past(walk_r)} && cpl_entry[2] == $past(snoop_control_bit)
    && cpl_entry[9] == $past(transient_mapping_bit) && cpl_entry[11] == ($past(walk_level) != 2'h0))
    else $error("entry bits differ from walk results");
endmodule
bind atsr_responder atsr_asserts u_chk (.clk_sys, .rstn, .req_valid, .req_ready, .walk_req,
  .walk_addr, .walk_fault, .walk_r, .walk_w, .snoop_control_bit, .transient_mapping_bit,
  .walk_level, .cpl_valid, .cpl_ready, .cpl_status, .cpl_rid, .cpl_entry, .flt_valid,
  .flt_reason, .flt_qualified, .flt_rid);
`default_nettype wire

/* File: tb/atsr_endpoint.sv */
/*
  atsr_endpoint: requester model with a device translation cache.
  assumes: the bench calls send; one request outstanding at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module atsr_endpoint (
  input  wire logic        clk_sys,
  input  wire logic        req_ready,
  output logic             req_valid,
  output logic      [63:0] req_addr,
  output logic      [15:0] req_rid,
  output logic      [7:0]  req_tag,
  input  wire logic        cpl_valid,
  output logic             cpl_ready,
  input  wire logic [2:0]  cpl_status,
  input  wire logic [63:0] cpl_entry,
  input  wire logic [15:0] cpl_rid,
  input  wire logic [7:0]  cpl_tag
);
  logic [2:0]  got_status;
  logic [63:0] got_entry;
  logic [15:0] got_rid;
  logic [7:0]  got_tag;
  initial begin
    req_valid = 1'h0;
    req_addr = 64'h0;
    req_rid = 16'h0;
    req_tag = 8'h0;
    cpl_ready = 1'h0;
  end
  task automatic send(input logic [63:0] a, input logic [15:0] rid,
                      input logic [7:0] tag, input logic [1:0] stall);
    @(posedge clk_sys);
    req_valid <= 1'h1;
    req_addr <= a;
    req_rid <= rid;
    req_tag <= tag;
    do @(negedge clk_sys); while (!req_ready);
    @(posedge clk_sys);
    // released lines must not look like a held request
    req_valid <= 1'h0;
    req_addr <= ~a;
    req_rid <= ~rid;
    req_tag <= ~tag;
    repeat (stall) @(posedge clk_sys);
    cpl_ready <= 1'h1;
    do @(negedge clk_sys); while (!cpl_valid);
    got_status = cpl_status;
    got_entry = cpl_entry;
    got_rid = cpl_rid;
    got_tag = cpl_tag;
    @(posedge clk_sys);
    cpl_ready <= 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: tb/ats_translation_request_responder_test.sv */
/*
  bench for atsr_responder: endpoint model in front, walker answers
  from bench variables, registers over the plain port.
  assumes: atsr_pkg compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ats_translation_request_responder_test;
  logic clk_sys, rstn, req_valid, req_ready, walk_req, walk_done, walk_fault;
  logic fault_report_disable, walk_nonleaf_np, walk_r, walk_w, snoop_control_bit;
  logic transient_mapping_bit, cpl_valid, cpl_ready, flt_valid, flt_qualified;
  logic reg_wr, reg_rd, irq;
  logic [63:0] req_addr, walk_addr, cpl_entry, flt_addr, a;
  logic [15:0] req_rid, walk_rid, cpl_rid, flt_rid;
  logic [7:0]  req_tag, cpl_tag, reg_addr;
  logic [3:0]  walk_reason, flt_reason;
  logic [2:0]  context_addr_width, cpl_status;
  logic [1:0]  walk_level, rw;
  logic [51:0] walk_paddr;
  logic [31:0] reg_wdata, reg_rdata, d, r;
  logic [31:0] lfsr_q = 32'h000122af;
  logic [3:0]  codes [7] = '{4'h3, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
  int miscompares = 0;
  int samples_checked = 0;

  atsr_responder dut (.clk_sys, .rstn, .req_valid, .req_ready, .req_addr, .req_rid,
    .req_tag, .walk_req, .walk_addr, .walk_rid, .walk_done, .walk_fault, .walk_reason,
    .fault_report_disable, .context_addr_width, .walk_nonleaf_np, .walk_r, .walk_w,
    .snoop_control_bit, .transient_mapping_bit, .walk_level, .walk_paddr, .cpl_valid,
    .cpl_ready, .cpl_status, .cpl_rid, .cpl_tag, .cpl_entry, .flt_valid, .flt_reason,
    .flt_qualified, .flt_rid, .flt_addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq);
  atsr_endpoint ep (.clk_sys, .req_ready, .req_valid, .req_addr, .req_rid, .req_tag,
    .cpl_valid, .cpl_ready, .cpl_status, .cpl_entry, .cpl_rid, .cpl_tag);

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // walker answers one cycle after each walk request
  always @(posedge clk_sys or negedge rstn)
    walk_done <= rstn & walk_req;

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  function automatic logic [63:0] exp_entry(input logic [1:0] p, input logic n, u,
                                            input logic [1:0] lv, input logic [51:0] pa);
    logic [63:0] e;
    e = {pa, 12'h000};
    for (int b = 12; b < 11 + 9 * lv; b++) e[b] = 1'h1;
    if (lv != 2'h0) e[11 + 9 * lv] = 1'h0;
    e[1:0] = p;
    e[2] = n;
    e[9] = u;
    e[11] = lv != 2'h0;
    return e;
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  task automatic xact(input logic [63:0] ad, input logic [2:0] st, input logic [63:0] ee);
    logic [31:0] t;
    logic [63:0] m;
    t = rnd();
    ep.send(ad, t[15:0], t[23:16], t[25:24]);
    `CHK(walk_addr, ad)
    `CHK(walk_rid, t[15:0])
    `CHK(flt_addr, ad)
    m = ee[9] ? 64'hfff : '1;
    `CHK(ep.got_status, st)
    `CHK(ep.got_entry & m, ee & m)
    `CHK(ep.got_rid, t[15:0])
    `CHK(ep.got_tag, t[23:16])
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end

  initial begin
    {rstn, walk_fault, fault_report_disable, walk_nonleaf_np, snoop_control_bit} = 5'h0;
    {transient_mapping_bit, reg_wr, reg_rd, walk_level, walk_reason} = 9'h0;
    {walk_r, walk_w, walk_paddr, reg_addr, reg_wdata} = 94'h0;
    context_addr_width = 3'h2;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'h1;
    rd(atsr_pkg::REG_CTRL, d);
    `CHK(d, 32'h00000630)
    rd(8'h20, d);
    `CHK(d, 32'h0)
    for (int i = 0; i < 7; i++) begin
      for (int f = 0; f < 2; f++) begin
        r = rnd();
        walk_fault <= 1'h1;
        walk_reason <= codes[i];
        fault_report_disable <= f[0];
        xact({32'h0, 12'hfee, r[19:0]}, atsr_pkg::CPL_CA, 64'h0);
      end
    end
    walk_fault <= 1'h0;
    rd(atsr_pkg::REG_FCOUNT, d);
    `CHK(d[15:0], 16'h000b)
    rd(atsr_pkg::REG_LAST, d);
    `CHK(d[7:0], 8'h9c)
    rd(atsr_pkg::REG_STATUS, d);
    `CHK(d[3:0], 4'hb)
    wr(atsr_pkg::REG_ENABLE, 32'h2);
    `CHK(irq, 1'h1)
    wr(atsr_pkg::REG_ENABLE, 32'h0);
    `CHK(irq, 1'h0)
    wr(atsr_pkg::REG_CLEAR, 32'hf);
    rd(atsr_pkg::REG_STATUS, d);
    `CHK(d, 32'h0)
    wr(atsr_pkg::REG_ENABLE, 32'h4);
    `CHK(irq, 1'h0)
    context_addr_width <= 3'h3;
    xact(64'h1000, atsr_pkg::CPL_CA, 64'h0);
    context_addr_width <= 3'h1;
    {walk_r, walk_w} <= 2'h3;
    xact(64'h0000008000000000, atsr_pkg::CPL_SC, 64'h0);
    walk_paddr <= 52'h123456789abcd;
    xact(64'h0000007fffffffff, atsr_pkg::CPL_SC, exp_entry(2'h3, 1'h0, 1'h0, 2'h0, 52'h123456789abcd));
    `CHK(irq, 1'h1)
    transient_mapping_bit <= 1'h1;
    walk_w <= 1'h0;
    xact(64'h00000000fee12345, atsr_pkg::CPL_SC, 64'h202);
    walk_nonleaf_np <= 1'h1;
    xact(64'h4000, atsr_pkg::CPL_SC, 64'h0);
    walk_nonleaf_np <= 1'h0;
    walk_r <= 1'h0;
    xact(64'h5000, atsr_pkg::CPL_SC, 64'h0);
    context_addr_width <= 3'h2;
    for (int k = 0; k < 24; k++) begin
      r = rnd();
      a = {32'h1, rnd()};
      rw = r[1:0] == 2'h0 ? 2'h3 : r[1:0];
      {walk_w, walk_r} <= rw;
      snoop_control_bit <= r[2];
      transient_mapping_bit <= r[3];
      walk_level <= r[5:4];
      walk_paddr <= {r[31:12], a[31:0]};
      xact(a, atsr_pkg::CPL_SC, exp_entry(rw, r[2], r[3], r[5:4], {r[31:12], a[31:0]}));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
